// File: rtl/svga_access_decode.sv
// Summary of operation
// RULE1 - Legacy VGA memory range accesses go to SVGA frame memory.
// RULE2 - Frame memory word address is bus bits 16 down to 2.
// RULE3 - Higher bits ignored, so 128K memory repeats through the aperture.
// RULE4 - Aperture with its SVGA access bit set goes to frame memory.
// RULE5 - Aperture data passes unchanged, no byte swapping either way.
// RULE6 - Standard SVGA registers decoded at legacy IO port addresses.
// RULE7 - Registers also mapped in 4K window at offset 0x6000.
// RULE8 - Window register address is bits 9 to 2; four aliases per port.
// RULE9 - Extended control is sequencer index 5, data through 3C5.
// RULE10 - Control bits 4 and 5 drive RAMDAC address bits 2 and 3.
// RULE11 - Control bit 3 picks VGA display or graphics processor display.
// RULE12 - Control bit 6 stops VGA timing, only while hold bit is zero.
// RULE13 - Bank select is graphics index 9, data through 3CF.
// RULE14 - Bits 0 to 2 bank accesses between A0000 and B0000.
// RULE15 - Bits 3 to 5 bank accesses between B0000 and C0000.
// RULE16 - Bank bit 6 is display start bit 16 and reads as zero.
// RULE17 - Bank fields apply only while bank enable bit 7 is one.
// RULE18 - Control bits 0, 1 enable memory, RAMDAC; bit 2 gates interrupts.
// RULE19 - Control bit 7 ignores writes and reads as zero.
`default_nettype none
module svga_access_decode
  import sad_pkg::*;
#(
  parameter int MEM_AW = 17
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic host_req,
  input wire logic host_we,
  input wire logic [2:0] host_space,
  input wire logic [31:0] host_addr,
  input wire logic [3:0] host_be,
  input wire logic [31:0] host_wdata,
  output logic host_ack,
  output logic host_claimed,
  output logic [31:0] host_rdata,
  input wire logic first_aperture_svga,
  input wire logic second_aperture_svga,
  output logic mem_req,
  output logic mem_we,
  output logic [MEM_AW-1:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  output logic core_reg_req,
  output logic core_reg_we,
  output logic [9:0] core_reg_port,
  output logic [7:0] core_reg_wdata,
  input wire logic [7:0] core_reg_rdata,
  output logic ramdac_req,
  output logic ramdac_we,
  output logic [3:0] ramdac_addr,
  output logic [7:0] ramdac_wdata,
  input wire logic [7:0] ramdac_rdata,
  input wire logic core_irq,
  output logic svga_irq,
  input wire logic display_hold,
  output logic vga_display_sel,
  output logic vga_timing_stop,
  output logic svga_mem_enable,
  output logic ramdac_enable,
  output logic display_start_bit16,
  output logic banked_addressing
);

  typedef enum logic [2:0] {
    SAD_KIND_NONE = 3'h0,
    SAD_KIND_MEM = 3'h1,
    SAD_KIND_CORE = 3'h2,
    SAD_KIND_DAC = 3'h3,
    SAD_KIND_LOCAL = 3'h4
  } sad_kind_t;

  logic [7:0] ext_control_reg;
  logic [7:0] bank_select_reg;
  logic [7:0] seq_index_reg;
  logic [7:0] gfx_index_reg;
  sad_kind_t kind_reg;
  sad_kind_t kind_next;
  logic pend_reg;
  logic pend_we_reg;
  logic [7:0] local_data_reg;
  logic [7:0] local_data_next;

  logic mem_hit;
  logic [MEM_AW-1:0] mem_addr_map;
  logic reg_hit;
  logic [9:0] reg_port;
  logic [7:0] wbyte;
  logic is_dac_port;
  logic ext_sel;
  logic bank_sel;

  // ---------------------------------------------------------------
  // Address mapping
  // ---------------------------------------------------------------
  sad_mem_map #(
    .MEM_AW(MEM_AW)
  ) u_mem_map (
    .host_space(host_space),
    .host_addr(host_addr),
    .first_aperture_svga(first_aperture_svga),
    .second_aperture_svga(second_aperture_svga),
    .bank_select(bank_select_reg),
    .mem_hit(mem_hit),
    .mem_addr(mem_addr_map)
  );

  sad_reg_map u_reg_map (
    .host_space(host_space),
    .host_addr(host_addr),
    .host_be(host_be),
    .reg_hit(reg_hit),
    .reg_port(reg_port)
  );

  // Byte of write data on the addressed lane
  assign wbyte = host_wdata[8*sad_lane(host_be) +: 8];

  // ---------------------------------------------------------------
  // Request classification
  // ---------------------------------------------------------------
  assign is_dac_port = (reg_port >= SAD_PORT_DAC_FIRST) &&
                       (reg_port <= SAD_PORT_DAC_LAST);
  // RULE9 sequencer index 5
  assign ext_sel = (reg_port == SAD_PORT_SEQ_DATA) &&
                   (seq_index_reg == SAD_IDX_EXT_CONTROL);
  // RULE13 graphics index 9
  assign bank_sel = (reg_port == SAD_PORT_GFX_DATA) &&
                    (gfx_index_reg == SAD_IDX_BANK_SELECT);

  // Kind of access and locally answered read data
  always_comb begin
    kind_next = SAD_KIND_NONE;
    local_data_next = 8'h00;
    if (host_req && mem_hit) begin
      // RULE18 memory enable gate
      if (ext_control_reg[SAD_EXT_MEM_EN]) begin
        kind_next = SAD_KIND_MEM;
      end else begin
        kind_next = SAD_KIND_LOCAL;
      end
    end else if (host_req && reg_hit) begin
      if (ext_sel) begin
        kind_next = SAD_KIND_LOCAL;
        // RULE19 reserved bit reads zero
        local_data_next = ext_control_reg & SAD_EXT_CONTROL_WMASK;
      end else if (bank_sel) begin
        kind_next = SAD_KIND_LOCAL;
        // RULE16 start bit reads zero
        local_data_next = bank_select_reg & SAD_BANK_SELECT_RMASK;
      end else if (is_dac_port) begin
        // RULE18 RAMDAC enable gate
        if (ext_control_reg[SAD_EXT_DAC_EN]) begin
          kind_next = SAD_KIND_DAC;
        end else begin
          kind_next = SAD_KIND_LOCAL;
        end
      end else begin
        kind_next = SAD_KIND_CORE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Index snooping
  // ---------------------------------------------------------------
  // Index writes also pass on to the SVGA core
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seq_index_reg <= 8'h00;
      gfx_index_reg <= 8'h00;
    end else if (host_req && host_we && reg_hit) begin
      if (reg_port == SAD_PORT_SEQ_INDEX) begin
        seq_index_reg <= wbyte;
      end
      if (reg_port == SAD_PORT_GFX_INDEX) begin
        gfx_index_reg <= wbyte;
      end
    end
  end

  // ---------------------------------------------------------------
  // Extended registers
  // ---------------------------------------------------------------
  // RULE9 control write through 3C5
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_control_reg <= SAD_EXT_CONTROL_RESET;
    end else if (host_req && host_we && reg_hit && ext_sel) begin
      // RULE19 reserved bit ignores writes
      ext_control_reg <= wbyte & SAD_EXT_CONTROL_WMASK;
    end
  end

  // RULE13 bank write through 3CF
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bank_select_reg <= SAD_BANK_SELECT_RESET;
    end else if (host_req && host_we && reg_hit && bank_sel) begin
      bank_select_reg <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // Frame memory request stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_be <= 4'h0;
      mem_wdata <= 32'h00000000;
    end else begin
      mem_req <= (kind_next == SAD_KIND_MEM);
      mem_we <= host_we && (kind_next == SAD_KIND_MEM);
      if (kind_next == SAD_KIND_MEM) begin
        mem_addr <= mem_addr_map;
        mem_be <= host_be;
        // RULE5 data passed unchanged
        mem_wdata <= host_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // SVGA core register request stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_reg_req <= 1'b0;
      core_reg_we <= 1'b0;
      core_reg_port <= 10'h000;
      core_reg_wdata <= 8'h00;
    end else begin
      core_reg_req <= (kind_next == SAD_KIND_CORE);
      core_reg_we <= host_we && (kind_next == SAD_KIND_CORE);
      if (kind_next == SAD_KIND_CORE) begin
        // RULE6 legacy port forwarded
        core_reg_port <= reg_port;
        core_reg_wdata <= wbyte;
      end
    end
  end

  // ---------------------------------------------------------------
  // RAMDAC request stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ramdac_req <= 1'b0;
      ramdac_we <= 1'b0;
      ramdac_addr <= 4'h0;
      ramdac_wdata <= 8'h00;
    end else begin
      ramdac_req <= (kind_next == SAD_KIND_DAC);
      ramdac_we <= host_we && (kind_next == SAD_KIND_DAC);
      if (kind_next == SAD_KIND_DAC) begin
        // RULE10 extension address bits
        ramdac_addr <= {ext_control_reg[SAD_EXT_DAC_A3],
                        ext_control_reg[SAD_EXT_DAC_A2],
                        reg_port[1:0]};
        ramdac_wdata <= wbyte;
      end
    end
  end

  // ---------------------------------------------------------------
  // Answer stage
  // ---------------------------------------------------------------
  // Tracks the access in flight between request and answer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      kind_reg <= SAD_KIND_NONE;
      pend_reg <= 1'b0;
      pend_we_reg <= 1'b0;
      local_data_reg <= 8'h00;
    end else begin
      kind_reg <= kind_next;
      pend_reg <= host_req;
      pend_we_reg <= host_we;
      local_data_reg <= local_data_next;
    end
  end

  // Every request is answered one cycle after its stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      host_ack <= 1'b0;
      host_claimed <= 1'b0;
      host_rdata <= 32'h00000000;
    end else begin
      host_ack <= pend_reg;
      host_claimed <= pend_reg && (kind_reg != SAD_KIND_NONE);
      host_rdata <= 32'h00000000;
      if (pend_reg && !pend_we_reg) begin
        case (kind_reg)
          // RULE5 read data unchanged
          SAD_KIND_MEM: host_rdata <= mem_rdata;
          SAD_KIND_CORE: host_rdata <= {4{core_reg_rdata}};
          SAD_KIND_DAC: host_rdata <= {4{ramdac_rdata}};
          SAD_KIND_LOCAL: host_rdata <= {4{local_data_reg}};
          default: host_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Display and control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vga_display_sel <= 1'b0;
      vga_timing_stop <= 1'b0;
      svga_mem_enable <= 1'b0;
      ramdac_enable <= 1'b0;
      display_start_bit16 <= 1'b0;
      banked_addressing <= 1'b0;
    end else begin
      // RULE11 display source select
      vga_display_sel <= ext_control_reg[SAD_EXT_VGA_SEL];
      // RULE12 timing stop under hold
      vga_timing_stop <= ext_control_reg[SAD_EXT_TIMING_STOP] &&
                         !display_hold;
      // RULE18 enables shown
      svga_mem_enable <= ext_control_reg[SAD_EXT_MEM_EN];
      ramdac_enable <= ext_control_reg[SAD_EXT_DAC_EN];
      // RULE16 display start bit
      display_start_bit16 <= bank_select_reg[SAD_BANK_START16];
      // RULE17 banking enable shown
      banked_addressing <= bank_select_reg[SAD_BANK_ENABLE];
    end
  end

  // Interrupt from the SVGA core
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      svga_irq <= 1'b0;
    end else begin
      // RULE18 interrupt gate
      svga_irq <= core_irq && ext_control_reg[SAD_EXT_IRQ_GATE];
    end
  end

endmodule : svga_access_decode
`default_nettype wire

// File: include/sad_pkg.sv
`default_nettype none
package sad_pkg;

  // ---------------------------------------------------------------
  // Host access spaces
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SAD_SPACE_LEGACY_MEM = 3'h0,
    SAD_SPACE_LEGACY_IO = 3'h1,
    SAD_SPACE_APERTURE1 = 3'h2,
    SAD_SPACE_APERTURE2 = 3'h3,
    SAD_SPACE_REGION0 = 3'h4
  } sad_space_t;

  // ---------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------
  localparam logic [31:0] SAD_LEGACY_LOW_BASE = 32'h000A0000;
  localparam logic [31:0] SAD_LEGACY_HIGH_BASE = 32'h000B0000;
  localparam logic [31:0] SAD_LEGACY_END = 32'h000C0000;
  localparam logic [31:0] SAD_MMIO_BASE = 32'h00006000;
  localparam logic [31:0] SAD_MMIO_SIZE = 32'h00001000;
  localparam int SAD_MEM_LSB = 2;
  localparam int SAD_MEM_MSB = 16;
  localparam int SAD_BANK_LSB = 15;
  localparam int SAD_REG_LSB = 2;
  localparam int SAD_REG_MSB = 9;

  // ---------------------------------------------------------------
  // IO ports and indices
  // ---------------------------------------------------------------
  localparam logic [9:0] SAD_PORT_SEQ_INDEX = 10'h3C4;
  localparam logic [9:0] SAD_PORT_SEQ_DATA = 10'h3C5;
  localparam logic [9:0] SAD_PORT_GFX_INDEX = 10'h3CE;
  localparam logic [9:0] SAD_PORT_GFX_DATA = 10'h3CF;
  localparam logic [9:0] SAD_PORT_DAC_FIRST = 10'h3C6;
  localparam logic [9:0] SAD_PORT_DAC_LAST = 10'h3C9;
  localparam logic [7:0] SAD_IDX_EXT_CONTROL = 8'h05;
  localparam logic [7:0] SAD_IDX_BANK_SELECT = 8'h09;

  // ---------------------------------------------------------------
  // Extended control fields
  // ---------------------------------------------------------------
  localparam logic [7:0] SAD_EXT_CONTROL_RESET = 8'h4B;
  localparam logic [7:0] SAD_EXT_CONTROL_WMASK = 8'h7F;
  localparam int SAD_EXT_MEM_EN = 0;
  localparam int SAD_EXT_DAC_EN = 1;
  localparam int SAD_EXT_IRQ_GATE = 2;
  localparam int SAD_EXT_VGA_SEL = 3;
  localparam int SAD_EXT_DAC_A2 = 4;
  localparam int SAD_EXT_DAC_A3 = 5;
  localparam int SAD_EXT_TIMING_STOP = 6;

  // ---------------------------------------------------------------
  // Bank select fields
  // ---------------------------------------------------------------
  localparam logic [7:0] SAD_BANK_SELECT_RESET = 8'h00;
  localparam logic [7:0] SAD_BANK_SELECT_RMASK = 8'hBF;
  localparam int SAD_BANK_LOW_LSB = 0;
  localparam int SAD_BANK_HIGH_LSB = 3;
  localparam int SAD_BANK_W = 3;
  localparam int SAD_BANK_START16 = 6;
  localparam int SAD_BANK_ENABLE = 7;

  // Lowest enabled byte lane of a byte enable group
  function automatic logic [1:0] sad_lane(input logic [3:0] be);
    logic [1:0] lane;
    lane = 2'h0;
    if (be[0]) begin
      lane = 2'h0;
    end else if (be[1]) begin
      lane = 2'h1;
    end else if (be[2]) begin
      lane = 2'h2;
    end else if (be[3]) begin
      lane = 2'h3;
    end
    return lane;
  endfunction : sad_lane

endpackage : sad_pkg
`default_nettype wire

// File: rtl/sad_mem_map.sv
`default_nettype none
module sad_mem_map
  import sad_pkg::*;
#(
  parameter int MEM_AW = 17
) (
  input wire logic [2:0] host_space,
  input wire logic [31:0] host_addr,
  input wire logic first_aperture_svga,
  input wire logic second_aperture_svga,
  input wire logic [7:0] bank_select,
  output logic mem_hit,
  output logic [MEM_AW-1:0] mem_addr
);

  logic in_low;
  logic in_high;
  logic [SAD_BANK_W-1:0] bank;
  logic [MEM_AW-1:0] plain_addr;
  logic [MEM_AW-1:0] banked_addr;

  // ---------------------------------------------------------------
  // Window classification
  // ---------------------------------------------------------------
  // RULE1 legacy memory range
  assign in_low = (host_addr >= SAD_LEGACY_LOW_BASE) &&
                  (host_addr < SAD_LEGACY_HIGH_BASE);
  assign in_high = (host_addr >= SAD_LEGACY_HIGH_BASE) &&
                   (host_addr < SAD_LEGACY_END);

  // Hit decode per space
  always_comb begin
    mem_hit = 1'b0;
    case (host_space)
      SAD_SPACE_LEGACY_MEM: mem_hit = in_low || in_high;
      // RULE4 aperture routing bits
      SAD_SPACE_APERTURE1: mem_hit = first_aperture_svga;
      SAD_SPACE_APERTURE2: mem_hit = second_aperture_svga;
      default: mem_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Address formation
  // ---------------------------------------------------------------
  // RULE2 bits 16 to 2
  // RULE3 upper bits ignored, aliasing
  assign plain_addr = MEM_AW'(host_addr[SAD_MEM_MSB:SAD_MEM_LSB]);

  // RULE14 low window bank
  // RULE15 high window bank
  assign bank = in_high ?
    bank_select[SAD_BANK_HIGH_LSB +: SAD_BANK_W] :
    bank_select[SAD_BANK_LOW_LSB +: SAD_BANK_W];
  assign banked_addr = MEM_AW'({bank,
    host_addr[SAD_BANK_LSB:SAD_MEM_LSB]});

  // RULE17 banking only when enabled
  assign mem_addr = (host_space == SAD_SPACE_LEGACY_MEM &&
                     bank_select[SAD_BANK_ENABLE]) ?
                    banked_addr : plain_addr;

endmodule : sad_mem_map
`default_nettype wire

// File: rtl/sad_reg_map.sv
`default_nettype none
module sad_reg_map
  import sad_pkg::*;
(
  input wire logic [2:0] host_space,
  input wire logic [31:0] host_addr,
  input wire logic [3:0] host_be,
  output logic reg_hit,
  output logic [9:0] reg_port
);

  logic mmio_hit;

  // ---------------------------------------------------------------
  // Register window decode
  // ---------------------------------------------------------------
  // RULE7 4K window at 0x6000
  assign mmio_hit = (host_space == SAD_SPACE_REGION0) &&
                    (host_addr >= SAD_MMIO_BASE) &&
                    (host_addr < SAD_MMIO_BASE + SAD_MMIO_SIZE);

  // RULE6 legacy IO decode
  assign reg_hit = mmio_hit || (host_space == SAD_SPACE_LEGACY_IO);

  // RULE8 bits 9 to 2, lane from enables
  assign reg_port = {host_addr[SAD_REG_MSB:SAD_REG_LSB], sad_lane(host_be)};

endmodule : sad_reg_map
`default_nettype wire

// File: verification/sad_checker_assertions.sv
`default_nettype none
module sad_checker
  import sad_pkg::*;
#(
  parameter int MEM_AW = 17
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic host_req,
  input wire logic [2:0] host_space,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] host_wdata,
  input wire logic host_ack,
  input wire logic [31:0] host_rdata,
  input wire logic first_aperture_svga,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [MEM_AW-1:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic ramdac_req,
  input wire logic core_irq,
  input wire logic svga_irq,
  input wire logic display_hold,
  input wire logic vga_timing_stop
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------
  // Host side timing and data paths
  // ------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_ack_delay: assert property (host_req |=> ##1 host_ack)
    else $error("ack late");
  chk_ack_cause: assert property (host_ack |-> $past(host_req, 2))
    else $error("stray ack");
  chk_rdata_idle: assert property (
    !host_ack |-> host_rdata == 32'h0
  ) else $error("stray read data");
  chk_aperture_gate: assert property (
    mem_req && $past(host_space) == SAD_SPACE_APERTURE1
    |-> $past(first_aperture_svga)
  ) else $error("aperture not routed");
  chk_aperture_addr: assert property (
    mem_req && $past(host_space) == SAD_SPACE_APERTURE2
    |-> mem_addr == MEM_AW'($past(host_addr[16:2]))
  ) else $error("aperture address");
  chk_wdata_pass: assert property (
    mem_req && mem_we |-> mem_wdata == $past(host_wdata)
  ) else $error("write data altered");
  chk_rdata_pass: assert property (
    mem_req && !mem_we |=> host_rdata == $past(mem_rdata)
  ) else $error("read data altered");
  chk_dac_port: assert property (
    ramdac_req |-> $past(host_addr[9:2]) inside {8'hF1, 8'hF2}
  ) else $error("ramdac port");
  chk_stop_hold: assert property (
    vga_timing_stop |-> !$past(display_hold)
  ) else $error("stop under hold");
  chk_irq_gate: assert property (svga_irq |-> $past(core_irq))
    else $error("ungated interrupt");

  cov_mem_read: cover property (mem_req && !mem_we);
  cov_dac: cover property (ramdac_req);
  cov_irq: cover property (svga_irq);
endmodule : sad_checker
`default_nettype wire

// File: verification/sad_far_model.sv
`default_nettype none
module sad_far_model (
  input wire logic clk,
  input wire logic mem_req,
  input wire logic [16:0] mem_addr,
  output logic [31:0] mem_rdata,
  input wire logic core_reg_req,
  input wire logic [9:0] core_reg_port,
  output logic [7:0] core_reg_rdata,
  input wire logic ramdac_req,
  input wire logic [3:0] ramdac_addr,
  output logic [7:0] ramdac_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] junk_reg = 32'h0;
  // Fresh junk each cycle
  always_ff @(posedge clk) begin
    junk_reg <= junk_reg + 32'h9E3779B9;
  end
  // Data only while selected
  assign mem_rdata = mem_req ? {15'h2A5B, mem_addr} : junk_reg;
  assign core_reg_rdata = core_reg_req ? core_reg_port[7:0] ^ 8'h5C
      : junk_reg[7:0];
  assign ramdac_rdata = ramdac_req ? {4'hA, ramdac_addr} : junk_reg[15:8];
endmodule : sad_far_model
`default_nettype wire

// File: verification/tb.sv
`default_nettype none
bind svga_access_decode sad_checker #(.MEM_AW(MEM_AW)) i_sad_checker (
  .clk, .reset, .host_req, .host_space, .host_addr, .host_wdata,
  .host_ack, .host_rdata, .first_aperture_svga, .mem_req, .mem_we,
  .mem_addr, .mem_wdata, .mem_rdata, .ramdac_req, .core_irq, .svga_irq,
  .display_hold, .vga_timing_stop
);
module tb
  import sad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset = 1'b1, host_req = 1'b0, host_we = 1'b0;
  logic first_aperture_svga = 1'b0, second_aperture_svga = 1'b0;
  logic core_irq = 1'b0, display_hold = 1'b0;
  logic [2:0] host_space = 3'h0;
  logic [3:0] host_be = 4'h0;
  logic [31:0] host_addr = 32'h0, host_wdata = 32'h0;
  logic host_ack, host_claimed, mem_req, mem_we, core_reg_req, core_reg_we;
  logic ramdac_req, ramdac_we, svga_irq, vga_display_sel, vga_timing_stop;
  logic svga_mem_enable, ramdac_enable, display_start_bit16;
  logic banked_addressing;
  logic [31:0] host_rdata, mem_wdata, mem_rdata, s_mwd, s_rd;
  logic [3:0] mem_be, ramdac_addr;
  logic [16:0] mem_addr, s_maddr;
  logic [9:0] core_reg_port, s_dac;
  logic [7:0] core_reg_wdata, core_reg_rdata, ramdac_wdata, ramdac_rdata;
  logic [5:0] s_mbe;
  logic [19:0] s_core;
  logic s_clm;
  int mismatches = 0, check_count = 0;

  svga_access_decode i_svga_access_decode (
    .clk, .reset, .host_req, .host_we, .host_space, .host_addr, .host_be,
    .host_wdata, .host_ack, .host_claimed, .host_rdata,
    .first_aperture_svga, .second_aperture_svga, .mem_req, .mem_we,
    .mem_addr, .mem_be, .mem_wdata, .mem_rdata, .core_reg_req,
    .core_reg_we, .core_reg_port, .core_reg_wdata, .core_reg_rdata,
    .ramdac_req, .ramdac_we, .ramdac_addr, .ramdac_wdata, .ramdac_rdata,
    .core_irq, .svga_irq, .display_hold, .vga_display_sel,
    .vga_timing_stop, .svga_mem_enable, .ramdac_enable,
    .display_start_bit16, .banked_addressing
  );
  sad_far_model i_sad_far_model (
    .clk, .mem_req, .mem_addr, .mem_rdata, .core_reg_req, .core_reg_port,
    .core_reg_rdata, .ramdac_req, .ramdac_addr, .ramdac_rdata
  );

  // Free running clock
  always #25 clk = ~clk;

  // -----------------------------
  // Checking and bus helpers
  // -----------------------------
  task automatic chk(input string n, logic [31:0] s, logic [31:0] x);
    check_count++;
    if (s !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task report_and_stop;
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // One host access
  task automatic acc(input logic [2:0] sp, logic [31:0] a, logic [3:0] be,
      logic we, logic [31:0] wd);
    @(posedge clk);
    host_req <= 1'b1;
    host_space <= sp;
    host_addr <= a;
    host_be <= be;
    host_we <= we;
    host_wdata <= wd;
    @(posedge clk);
    host_req <= 1'b0;
    #1;
    s_mbe = {mem_req, mem_we, mem_be} & {6{mem_req}};
    s_maddr = mem_addr;
    s_mwd = mem_wdata;
    s_dac = {ramdac_req, ramdac_we, ramdac_wdata} & {10{ramdac_req}};
    s_core = {core_reg_req, core_reg_we, core_reg_port, core_reg_wdata};
    @(posedge clk);
    #1;
    s_clm = host_claimed;
    s_rd = host_rdata;
    chk("ack", host_ack, 1'b1);
  endtask : acc

  // IO space or the mapped window
  function automatic logic [2:0] rsp();
    return ($urandom & 1) ? SAD_SPACE_REGION0 : SAD_SPACE_LEGACY_IO;
  endfunction : rsp

  // Byte access to one port
  task automatic pr(input logic [2:0] sp, logic [9:0] p, logic [7:0] v,
      logic we);
    logic [31:0] a;
    a = {22'h0, p[9:2], 2'h0};
    if (sp == SAD_SPACE_REGION0) begin
      a = a | 32'h6000 | ($urandom & 32'hC00);
    end
    acc(sp, a, 4'h1 << p[1:0], we, {4{v}});
  endtask : pr

  // Index then data port
  task automatic xreg(input logic [9:0] ip, logic [7:0] idx, logic [7:0] v,
      logic we);
    logic [2:0] sp;
    sp = rsp();
    pr(sp, ip, idx, 1'b1);
    pr(sp, ip + 10'h1, v, we);
  endtask : xreg

  // Expected word address
  function automatic logic [16:0] exp_maddr(input logic lg,
      input logic [31:0] a, input logic [7:0] b);
    if (lg && b[7]) begin
      return {a[16] ? b[5:3] : b[2:0], a[15:2]};
    end
    return {2'h0, a[16:2]};
  endfunction : exp_maddr

  // Main sequence
  initial begin
    logic [7:0] e, b;
    logic [31:0] a, wd;
    logic [16:0] ma;
    logic [9:0] p;
    logic we, go;
    void'($urandom(32'h9F7693E7));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk("rst", {vga_display_sel, svga_mem_enable, ramdac_enable,
        vga_timing_stop, banked_addressing, display_start_bit16},
        6'h3C);
    xreg(SAD_PORT_SEQ_INDEX, SAD_IDX_EXT_CONTROL, 8'h00, 1'b0);
    chk("ext0", s_rd, {4{8'h4B}});
    xreg(SAD_PORT_GFX_INDEX, SAD_IDX_BANK_SELECT, 8'h00, 1'b0);
    chk("bank0", s_rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      e = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      b = 8'($urandom);
      @(posedge clk);
      display_hold <= 1'($urandom);
      core_irq <= (i == 0) | 1'($urandom);
      first_aperture_svga <= (i == 0) | 1'($urandom);
      second_aperture_svga <= (i == 0) | 1'($urandom);
      xreg(SAD_PORT_SEQ_INDEX, SAD_IDX_EXT_CONTROL, e, 1'b1);
      xreg(SAD_PORT_SEQ_INDEX, SAD_IDX_EXT_CONTROL, 8'h00, 1'b0);
      chk("ext", s_rd, {4{e & 8'h7F}});
      xreg(SAD_PORT_GFX_INDEX, SAD_IDX_BANK_SELECT, b, 1'b1);
      xreg(SAD_PORT_GFX_INDEX, SAD_IDX_BANK_SELECT, 8'h00, 1'b0);
      chk("bank", s_rd, {4{b & 8'hBF}});
      chk("lvl", {vga_display_sel, svga_mem_enable, ramdac_enable,
          display_start_bit16, banked_addressing},
          {e[3], e[0], e[1], b[6], b[7]});
      chk("stop", vga_timing_stop, e[6] & !display_hold);
      chk("irq", svga_irq, core_irq & e[2]);
      // Legacy window, then each aperture
      for (int k = 0; k < 3; k++) begin
        a = (k == 0) ? 32'hA0000 + ($urandom & 32'h1FFFF)
                     : $urandom & 32'h7FFFFF;
        we = 1'($urandom);
        wd = $urandom;
        acc((k == 0) ? SAD_SPACE_LEGACY_MEM : 3'(k + 1), a, wd[3:0], we, wd);
        go = (k == 0) | (k == 1 ? first_aperture_svga : second_aperture_svga);
        chk("claim", s_clm, go);
        go = go & e[0];
        ma = exp_maddr(k == 0, a, b);
        chk("mreq", s_mbe, {go, go & we, wd[3:0] & {4{go}}});
        chk("maddr", s_maddr & {17{go}}, ma & {17{go}});
        chk("mwd", s_mwd & {32{go & we}}, wd & {32{go & we}});
        chk("mrd", s_rd, (go & !we) ? {15'h2A5B, ma} : 32'h0);
      end
      p = SAD_PORT_DAC_FIRST + 10'($urandom & 3);
      pr(rsp(), p, wd[7:0], we);
      chk("dreq", s_dac, {e[1], e[1] & we, wd[7:0] & {8{e[1]}}});
      go = e[1] & !we;
      chk("drd", s_rd, go ? {4{4'hA, e[5:4], p[1:0]}} : 32'h0);
      pr(rsp(), 10'h3DA, wd[15:8], !we);
      chk("cport", s_core, {1'b1, !we, 10'h3DA, wd[15:8]});
      chk("crd", s_rd, we ? {4{8'h86}} : 32'h0);
      acc(SAD_SPACE_REGION0, 32'h5000 | ($urandom & 32'hFFC), 4'h1, 1'b0,
          32'h0);
      chk("nohit", s_rd | s_clm, 32'h0);
    end
    report_and_stop();
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
